// File: include/flash_prot_consts.svh
// Functional notes
// - flash is erased in 1-KB blocks; erase sets every bit to one.
// - program acts on one 32-bit word and only clears bits.
// - two adjacent erase blocks form one 2-KB protection region.
// - read-only regions refuse every erase and program.
// - execute-only regions refuse changes and serve only instruction fetches.
// - operation timing derives from a stored cycles-per-microsecond count.
// - reset loads the cycles-per-microsecond count for the maximum clock.
// - each region has a program-enable and a read-enable bit, 32-bit registers.
// - program-enable one allows program and erase; zero forbids change.
// - read-enable zero makes the region execute-only for data reads.
// - both bits zero: execute-only, no writes, erases or data reads.
// - program one, read zero: writes, erases, execution, no data reads.
// - program zero, read one: read-only, reads and execution allowed.
// - both bits one: region fully open.
// - program or erase of protected region blocked; masked interrupt raised.
// - data read of read-protected region blocked; optional interrupt reported.
// - a refused data read returns an all-zero word.
// - every protection bit defaults to one from the factory.
// - protection writes act at once but persist only after commit.
// - power-on reset restores uncommitted protection bits from stored values.
// - committing protection bits can only change ones into zeros.
// - commit starts on key-plus-commit write to control; software polls completion.
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH
`define OFS_ADDR        12'h000
`define OFS_DATA        12'h004
`define OFS_CTRL        12'h008
`define OFS_RIS         12'h00C
`define OFS_IM          12'h010
`define OFS_MISC        12'h014
`define OFS_RDEN0_ALT   12'h130
`define OFS_PROG0_ALT   12'h134
`define OFS_USEC        12'h140
`define OFS_RDEN0       12'h200
`define OFS_RDEN1       12'h204
`define OFS_PROG0       12'h400
`define OFS_PROG1       12'h404
`define CTRL_KEY        16'hA442
`define CTRL_WRITE      4'h1
`define CTRL_ERASE      4'h2
`define CTRL_MERASE     4'h4
`define CTRL_COMMIT     4'h8
`define USEC_RESET      8'h31
`define FACTORY_BITS    32'hFFFF_FFFF
`define ADDR_W          17
`define WORD_AW         15
`define FLASH_WORDS     32768
`define REGION_LSB      11
`define BLOCK_LSB       10
`define PROG_TIME_US    16'h0014
`define ERASE_TIME_US   16'h0064
`define MERASE_TIME_US  16'h00C8
`define RIS_ACCESS      0
`define RIS_DONE        1
`define COMMIT_RDEN0    17'h0_0000
`define COMMIT_PROG0    17'h0_0001
`define COMMIT_RDEN1    17'h0_0002
`define COMMIT_PROG1    17'h0_0003
`endif

// File: include/flash_prot_pkg.sv
package flash_prot_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TIME  = 2'b01,
    ST_APPLY = 2'b10
  } op_state_type;
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic [16:0] addr;
  } rd_req_type;
  typedef struct packed {
    logic        valid;
    logic        refused;
    logic [31:0] data;
  } rd_rsp_type;
endpackage

// File: rtl/flash_block_protection_timing.sv
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_consts.svh"
module flash_block_protection_timing (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      nv_resetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output var  logic                      hreadyout,
  output var  logic                      hresp,
  output var  logic [31:0]               hrdata,
  input  wire flash_prot_pkg::rd_req_type rd_req,
  output var  flash_prot_pkg::rd_rsp_type rd_rsp,
  output var  logic                      flash_irq
);

  // bus slave state
  logic                       wr_pend_r;
  logic                       rd_pend_r;
  logic [11:0]                ofs_r;
  logic [31:0]                rd_mux;
  logic                       addr_ok;
  // software-visible registers
  logic [`ADDR_W-1:0]         addr_r;
  logic [31:0]                data_r;
  logic [7:0]                 cycles_per_microsecond_reload_r;
  logic [31:0]                region_program_enable_bits_r [2];
  logic [31:0]                region_read_enable_bits_r [2];
  logic [31:0]                nv_prog_r [2];
  logic [31:0]                nv_rden_r [2];
  logic                       restore_pend_r;
  logic [1:0]                 flash_int_mask_reg_r;
  logic [1:0]                 ris_r;
  // operation engine
  flash_prot_pkg::op_state_type state_r;
  logic [3:0]                 op_r;
  logic [`WORD_AW-1:0]        cur_r;
  logic [`WORD_AW-1:0]        last_r;
  logic [15:0]                us_left_r;
  logic [7:0]                 usec_cnt_r;
  logic                       us_tick;
  logic                       ctrl_wr;
  logic [3:0]                 cmd;
  logic                       cmd_ok;
  logic                       start;
  logic                       deny;
  logic                       commit_bit;
  logic                       apply;
  logic                       op_done;
  logic                       rd_violation;
  logic [5:0]                 cmd_region;
  logic [5:0]                 rd_region;
  logic                       rd_allowed;
  logic [31:0]                flash_mem [0:`FLASH_WORDS-1];

  wire access_violation_int_mask = flash_int_mask_reg_r[`RIS_ACCESS];

  assign addr_ok = hsel && htrans[1] && hready;

  // address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ofs_r     <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        ofs_r <= haddr[11:0];
      end
      hreadyout <= !(addr_ok && !hwrite);
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ofs_r)
      `OFS_ADDR:      rd_mux = {15'h0000, addr_r};
      `OFS_DATA:      rd_mux = data_r;
      `OFS_CTRL:      rd_mux = {28'h000_0000, op_r};
      `OFS_RIS:       rd_mux = {30'h0000_0000, ris_r};
      `OFS_IM:        rd_mux = {30'h0000_0000, flash_int_mask_reg_r};
      `OFS_MISC:      rd_mux = {30'h0000_0000, ris_r & flash_int_mask_reg_r};
      `OFS_RDEN0_ALT,
      `OFS_RDEN0:     rd_mux = region_read_enable_bits_r[0];
      `OFS_RDEN1:     rd_mux = region_read_enable_bits_r[1];
      `OFS_PROG0_ALT,
      `OFS_PROG0:     rd_mux = region_program_enable_bits_r[0];
      `OFS_PROG1:     rd_mux = region_program_enable_bits_r[1];
      `OFS_USEC:      rd_mux = {24'h00_0000, cycles_per_microsecond_reload_r};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata <= rd_mux;
    end
  end

  // address and data holding registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= '0;
      data_r <= 32'h0000_0000;
    end else if (wr_pend_r && ofs_r == `OFS_ADDR) begin
      addr_r <= hwdata[`ADDR_W-1:0];
    end else if (wr_pend_r && ofs_r == `OFS_DATA) begin
      data_r <= hwdata;
    end
  end

  // microsecond time base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycles_per_microsecond_reload_r <= `USEC_RESET;
    end else if (wr_pend_r && ofs_r == `OFS_USEC) begin
      cycles_per_microsecond_reload_r <= hwdata[7:0];
    end
  end

  assign us_tick = (usec_cnt_r == 8'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      usec_cnt_r <= `USEC_RESET;
    end else if (us_tick || state_r == flash_prot_pkg::ST_IDLE) begin
      usec_cnt_r <= cycles_per_microsecond_reload_r;
    end else begin
      usec_cnt_r <= usec_cnt_r - 8'h01;
    end
  end

  // command decode
  assign ctrl_wr    = wr_pend_r && ofs_r == `OFS_CTRL
                      && hwdata[31:16] == `CTRL_KEY;
  assign cmd        = hwdata[3:0];
  assign cmd_ok     = cmd == `CTRL_WRITE || cmd == `CTRL_ERASE
                      || cmd == `CTRL_MERASE || cmd == `CTRL_COMMIT;
  assign cmd_region = addr_r[16:`REGION_LSB];
  assign commit_bit = (cmd == `CTRL_COMMIT);

  always_comb begin
    deny = 1'b0;
    if (cmd == `CTRL_WRITE || cmd == `CTRL_ERASE) begin
      // region program-enable selects
      deny = !(cmd_region[5]
               ? region_program_enable_bits_r[1][cmd_region[4:0]]
               : region_program_enable_bits_r[0][cmd_region[4:0]]);
    end else if (cmd == `CTRL_MERASE) begin
      deny = !(&region_program_enable_bits_r[0])
             || !(&region_program_enable_bits_r[1]);
    end
  end

  assign start   = ctrl_wr && cmd_ok
                   && state_r == flash_prot_pkg::ST_IDLE;
  assign apply   = state_r == flash_prot_pkg::ST_APPLY;
  assign op_done = apply && cur_r == last_r;

  // operation sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= flash_prot_pkg::ST_IDLE;
      op_r      <= 4'h0;
      cur_r     <= '0;
      last_r    <= '0;
      us_left_r <= 16'h0000;
    end else begin
      unique case (state_r)
        flash_prot_pkg::ST_IDLE: begin
          if (start && !deny) begin
            state_r <= flash_prot_pkg::ST_TIME;
            op_r    <= cmd;
            if (cmd == `CTRL_ERASE) begin
              cur_r     <= {addr_r[16:`BLOCK_LSB], 8'h00};
              last_r    <= {addr_r[16:`BLOCK_LSB], 8'hFF};
              us_left_r <= `ERASE_TIME_US;
            end else if (cmd == `CTRL_MERASE) begin
              cur_r     <= '0;
              last_r    <= '1;
              us_left_r <= `MERASE_TIME_US;
            end else begin
              cur_r     <= addr_r[16:2];
              last_r    <= addr_r[16:2];
              us_left_r <= `PROG_TIME_US;
            end
          end
        end
        flash_prot_pkg::ST_TIME: begin
          if (us_tick) begin
            us_left_r <= us_left_r - 16'h0001;
            if (us_left_r == 16'h0001) begin
              state_r <= flash_prot_pkg::ST_APPLY;
            end
          end
        end
        flash_prot_pkg::ST_APPLY: begin
          if (op_done) begin
            state_r <= flash_prot_pkg::ST_IDLE;
            op_r    <= 4'h0;
          end else begin
            cur_r <= cur_r + 1'b1;
          end
        end
        default: begin
          state_r <= flash_prot_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // flash array: erase sets ones, program only clears bits
  always_ff @(posedge hclk) begin
    if (apply && op_r == `CTRL_WRITE) begin
      flash_mem[cur_r] <= flash_mem[cur_r] & data_r;
    end else if (apply && op_r != `CTRL_COMMIT) begin
      flash_mem[cur_r] <= `FACTORY_BITS;
    end
  end

  // nonvolatile protection copies
  always_ff @(posedge hclk or negedge nv_resetn) begin
    if (!nv_resetn) begin
      nv_prog_r[0] <= `FACTORY_BITS;
      nv_prog_r[1] <= `FACTORY_BITS;
      nv_rden_r[0] <= `FACTORY_BITS;
      nv_rden_r[1] <= `FACTORY_BITS;
    end else if (apply && op_r == `CTRL_COMMIT) begin
      unique case (addr_r)
        `COMMIT_RDEN0: nv_rden_r[0] <= nv_rden_r[0]
                                       & region_read_enable_bits_r[0];
        `COMMIT_RDEN1: nv_rden_r[1] <= nv_rden_r[1]
                                       & region_read_enable_bits_r[1];
        `COMMIT_PROG0: nv_prog_r[0] <= nv_prog_r[0]
                                       & region_program_enable_bits_r[0];
        `COMMIT_PROG1: nv_prog_r[1] <= nv_prog_r[1]
                                       & region_program_enable_bits_r[1];
        default: begin
        end
      endcase
    end
  end

  // working protection registers, reloaded after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restore_pend_r <= 1'b1;
      region_program_enable_bits_r[0] <= `FACTORY_BITS;
      region_program_enable_bits_r[1] <= `FACTORY_BITS;
      region_read_enable_bits_r[0]    <= `FACTORY_BITS;
      region_read_enable_bits_r[1]    <= `FACTORY_BITS;
    end else if (restore_pend_r) begin
      restore_pend_r <= 1'b0;
      region_program_enable_bits_r <= nv_prog_r;
      region_read_enable_bits_r    <= nv_rden_r;
    end else if (wr_pend_r) begin
      unique case (ofs_r)
        `OFS_RDEN0_ALT,
        `OFS_RDEN0: region_read_enable_bits_r[0] <= hwdata;
        `OFS_RDEN1: region_read_enable_bits_r[1] <= hwdata;
        `OFS_PROG0_ALT,
        `OFS_PROG0: region_program_enable_bits_r[0] <= hwdata;
        `OFS_PROG1: region_program_enable_bits_r[1] <= hwdata;
        default: begin
        end
      endcase
    end
  end

  // read path policy
  assign rd_region  = rd_req.addr[16:`REGION_LSB];
  assign rd_allowed = rd_req.fetch
                      || (rd_region[5]
                          ? region_read_enable_bits_r[1][rd_region[4:0]]
                          : region_read_enable_bits_r[0][rd_region[4:0]]);
  assign rd_violation = rd_req.valid && !rd_allowed;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_rsp <= '0;
    end else begin
      rd_rsp.valid   <= rd_req.valid;
      rd_rsp.refused <= rd_violation;
      if (rd_req.valid && rd_allowed) begin
        // fetches always served
        rd_rsp.data <= flash_mem[rd_req.addr[16:2]];
      end else begin
        rd_rsp.data <= 32'h0000_0000;
      end
    end
  end

  // status and mask; a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_int_mask_reg_r <= 2'b00;
    end else if (wr_pend_r && ofs_r == `OFS_IM) begin
      flash_int_mask_reg_r <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ris_r <= 2'b00;
    end else begin
      if (wr_pend_r && ofs_r == `OFS_MISC) begin
        ris_r <= ris_r & ~hwdata[1:0];
      end
      if ((start && deny) || rd_violation) begin
        ris_r[`RIS_ACCESS] <= 1'b1;
      end
      if (op_done) begin
        ris_r[`RIS_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_irq <= 1'b0;
    end else begin
      flash_irq <= (ris_r[`RIS_ACCESS] && access_violation_int_mask)
                   || (ris_r[`RIS_DONE] && flash_int_mask_reg_r[`RIS_DONE]);
    end
  end

endmodule
`default_nettype wire

// File: tb/core_read_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_read_model (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       go,
  input  wire logic                       fetch,
  input  wire logic [16:0]                addr,
  output var  flash_prot_pkg::rd_req_type rd_req,
  input  wire flash_prot_pkg::rd_rsp_type rd_rsp,
  output var  logic                       got,
  output var  logic                       refused,
  output var  logic [31:0]                data
);
  // one-cycle request; idle lines toggle so stale values never match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_req <= '0;
    end else if (go) begin
      rd_req <= {1'b1, fetch, addr};
    end else begin
      rd_req <= {1'b0, ~rd_req.fetch, ~rd_req.addr};
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      got     <= 1'b0;
      refused <= 1'b0;
      data    <= 32'h0000_0000;
    end else begin
      got <= rd_rsp.valid;
      if (rd_rsp.valid) begin
        refused <= rd_rsp.refused;
        data    <= rd_rsp.data;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/flash_prot_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module flash_prot_assertions (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic [31:0]                hrdata,
  input wire flash_prot_pkg::rd_req_type rd_req,
  input wire flash_prot_pkg::rd_rsp_type rd_rsp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence ahb_rd_s;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  sequence rd_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  refused_zero_a: assert property (rd_rsp.refused |-> rd_rsp.data == 0)
    else $error("refused read gave nonzero data");
  fetch_served_a: assert property (rd_req.valid && rd_req.fetch |=>
    rd_rsp.valid && !rd_rsp.refused)
    else $error("fetch not served");
  data_answer_a: assert property (rd_req.valid && !rd_req.fetch |=> rd_rsp.valid)
    else $error("data read not answered");
  refusal_cause_a: assert property (rd_rsp.refused |->
    $past(rd_req.valid && !rd_req.fetch))
    else $error("refusal without data read");
  no_spare_rsp_a: assert property (!rd_req.valid |=> !rd_rsp.valid)
    else $error("answer without request");
  reg_read_wait_a: assert property (ahb_rd_s |=> rd_wait_s)
    else $error("register read timing wrong");
  reg_write_now_a: assert property (hsel && htrans[1] && hwrite && hready
    |=> hreadyout)
    else $error("register write stalled");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |->
    $stable(hrdata))
    else $error("read data changed without read");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_consts.svh"
module testbench;
  logic                       hclk, hresetn, nv_resetn, hsel, hwrite, go;
  logic                       fetch, got, refused, flash_irq, hreadyout;
  logic                       hresp, rf;
  logic [1:0]                 htrans;
  logic [31:0]                haddr, hwdata, hrdata, rdat, d;
  logic [16:0]                raddr;
  wire logic                  hready;
  flash_prot_pkg::rd_req_type rd_req;
  flash_prot_pkg::rd_rsp_type rd_rsp;
  int                         errors, checks, cyc, t0;
  assign hready = hreadyout;
  flash_block_protection_timing uut (.hclk(hclk), .hresetn(hresetn),
    .nv_resetn(nv_resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rd_req(rd_req),
    .rd_rsp(rd_rsp), .flash_irq(flash_irq));
  core_read_model cpu (.hclk(hclk), .hresetn(hresetn), .go(go),
    .fetch(fetch), .addr(raddr), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .got(got), .refused(refused), .data(rdat));
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 16) begin
      @(posedge hclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 16) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 16) begin
      errors++;
    end
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] q;
    xfer(1'b1, a, wd, q);
  endtask
  task automatic op(input logic [3:0] cmd);
    int n;
    n = 0;
    wr(`OFS_CTRL, {`CTRL_KEY, 12'h000, cmd});
    d = 32'hFFFF_FFFF;
    while (d[3:0] !== 4'h0 && n < 400) begin
      xfer(1'b0, `OFS_CTRL, 32'h0000_0000, d);
      n++;
    end
    if (n >= 400) begin
      errors++;
    end
  endtask
  task automatic prog(input logic [16:0] a, input logic [31:0] v);
    wr(`OFS_DATA, v);
    wr(`OFS_ADDR, {15'h0000, a});
    op(`CTRL_WRITE);
  endtask
  task automatic frd(input logic f, input logic [16:0] a);
    int n;
    n = 0;
    go <= 1'b1;
    fetch <= f;
    raddr <= a;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    while (got !== 1'b1 && n < 8) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 8) begin
      errors++;
    end
    d = rdat;
    rf = refused;
  endtask
  task automatic do_reset(input logic nv);
    hresetn <= 1'b0;
    nv_resetn <= ~nv;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    nv_resetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    hresetn = 0; nv_resetn = 0; hsel = 0; hwrite = 0; go = 0; fetch = 0;
    htrans = 0; haddr = 0; hwdata = 0; raddr = 0; errors = 0; checks = 0;
    cyc = 0;
    do_reset(1'b1);
    xfer(1'b0, `OFS_USEC, 0, d); chk(d, 32'h0000_0031);
    xfer(1'b0, `OFS_RDEN0, 0, d); chk(d, `FACTORY_BITS);
    xfer(1'b0, `OFS_RDEN1, 0, d); chk(d, `FACTORY_BITS);
    xfer(1'b0, `OFS_PROG0, 0, d); chk(d, `FACTORY_BITS);
    xfer(1'b0, `OFS_PROG1, 0, d); chk(d, `FACTORY_BITS);
    xfer(1'b0, 12'h208, 0, d); chk(d, 32'h0000_0000);
    wr(`OFS_USEC, 32'h0000_0003);
    wr(`OFS_ADDR, 32'h0000_0000);
    t0 = cyc;
    op(`CTRL_ERASE);
    chk(cyc - t0 >= 656 && cyc - t0 <= 690, 1);
    frd(0, 17'h0_0000); chk(d, 32'hFFFF_FFFF);
    frd(0, 17'h0_03FC); chk(d, 32'hFFFF_FFFF);
    prog(17'h0_0000, 32'h1234_5678);
    prog(17'h0_0000, 32'hFFFF_0000);
    frd(0, 17'h0_0000); chk(d, 32'h1234_0000);
    wr(`OFS_IM, 32'h0000_0001);
    wr(`OFS_PROG0, 32'hFFFF_FFFE);
    prog(17'h0_0000, 32'h0000_0000);
    xfer(1'b0, `OFS_RIS, 0, d); chk(d[0], 1);
    chk(flash_irq, 1);
    wr(`OFS_ADDR, 32'h0000_0000);
    op(`CTRL_ERASE);
    op(`CTRL_MERASE);
    frd(0, 17'h0_0000); chk(d, 32'h1234_0000);
    wr(`OFS_MISC, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    chk(flash_irq, 0);
    wr(`OFS_ADDR, 32'h0000_0800);
    op(`CTRL_ERASE);
    frd(0, 17'h0_0800); chk(d, 32'hFFFF_FFFF);
    wr(`OFS_RDEN0, 32'hFFFF_FFFE);
    xfer(1'b0, `OFS_RDEN0_ALT, 0, d); chk(d, 32'hFFFF_FFFE);
    frd(0, 17'h0_0000); chk(d, 32'h0000_0000);
    chk(rf, 1);
    xfer(1'b0, `OFS_RIS, 0, d); chk(d[0], 1);
    frd(1, 17'h0_07FC); chk(rf, 0);
    frd(1, 17'h0_0000); chk(d, 32'h1234_0000);
    chk(rf, 0);
    frd(0, 17'h0_0804); chk(rf, 0);
    wr(`OFS_PROG0, 32'hFFFF_FFFF);
    prog(17'h0_0000, 32'h0000_FFFF);
    frd(1, 17'h0_0000); chk(d, 32'h0000_0000);
    wr(`OFS_PROG0, 32'hFFFF_FFFE);
    wr(`OFS_ADDR, {15'h0000, `COMMIT_PROG0});
    op(`CTRL_COMMIT);
    wr(`OFS_PROG0, 32'hFFFF_FFFF);
    op(`CTRL_COMMIT);
    do_reset(1'b0);
    xfer(1'b0, `OFS_PROG0, 0, d); chk(d, 32'hFFFF_FFFE);
    xfer(1'b0, `OFS_RDEN0, 0, d); chk(d, `FACTORY_BITS);
    close_out();
  end
endmodule
bind flash_block_protection_timing flash_prot_assertions chk_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .rd_req(rd_req),
  .rd_rsp(rd_rsp));
`default_nettype wire
